// File: hw/usc_map.svh
// Register offsets, field positions, reset values and baud ratios of the serial transceiver.
`ifndef USC_MAP_SVH
`define USC_MAP_SVH
`define USC_OFF_TXCS 8'h00
`define USC_OFF_RXCS 8'h04
`define USC_OFF_DIV 8'h08
`define USC_OFF_TXDATA 8'h0C
`define USC_OFF_RXBUF 8'h10
`define USC_OFF_STAT 8'h14
`define USC_TXCS_RST 8'h02
`define USC_RXCS_RST 8'h00
`define USC_DIV_RST 8'h00
`define USC_B_CLOCK_SOURCE_SELECT 7
`define USC_B_TX9 6
`define USC_B_TRANSMIT_ENABLE 5
`define USC_B_SYNC 4
`define USC_B_HIGH_SPEED_SELECT 2
`define USC_B_SHIFT_REGISTER_EMPTY 1
`define USC_B_TRANSMIT_NINTH_BIT 0
`define USC_B_SERIAL_PORT_ENABLE 7
`define USC_B_RX9 6
`define USC_B_SINGLE_RECEIVE_ENABLE 5
`define USC_B_CONTINUOUS_RECEIVE_ENABLE 4
`define USC_B_ADDRESS_DETECT_ENABLE 3
`define USC_B_FRAMING_ERROR 2
`define USC_B_OVERRUN_ERROR 1
`define USC_B_RECEIVE_NINTH_BIT 0
`define USC_RATIO_LO 7'h40
`define USC_RATIO_HI 7'h10
`define USC_RATIO_SY 2'h3
`endif

// File: hw/usc_pkg.sv
// Types shared by the serial transceiver control block.
package usc_pkg;
	typedef struct packed {
		logic dtOut;
		logic dtOe;
		logic ckOut;
		logic ckOe;
	} usc_pin_t;

	typedef struct packed {
		logic [7:0]  txcs;
		logic [7:0]  rxcs;
		logic [7:0]  div;
		logic [7:0]  cnt;
		logic [7:0]  txData;
		logic        txFull;
		logic [10:0] txSh;
		logic [3:0]  txBits;
		logic [5:0]  txPh;
		logic        txBusy;
		logic        txSmp;
		logic [8:0]  rxSh;
		logic [3:0]  rxBits;
		logic [5:0]  rxPh;
		logic        rxBusy;
		logic [1:0]  rxVote;
		logic [7:0]  rxBuf;
		logic        rxValid;
		logic [1:0]  ph4;
		logic        ckLvl;
		logic        dtS1;
		logic        dtS2;
		logic        ckS1;
		logic        ckS2;
		logic        ckPrev;
		logic [31:0] prdata;
		usc_pin_t    pin;
	} usc_state_t;
endpackage

// File: hw/usc_ctrl.sv
// Control and status registers, baud timer and serial shifters of the serial transceiver.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "usc_map.svh"

// What this block does
// - Sync clock source: master internal, slave external.
// - Transmit width bit picks nine or eight.
// - Transmit enable; sync receive enables override it.
// - Mode bit selects synchronous or asynchronous.
// - High-speed bit picks async division ratio.
// - Shifter-empty status read-only, resets to one.
// - Control bit supplies ninth transmitted bit.
// - Port enable claims pins; clear disables port.
// - Receive width bit picks nine or eight.
// - Single receive takes one word, self-clears.
// - Continuous receive runs while set, beats single.
// - Address detect keeps only ninth-bit-set words.
// - Framing error updates only with next buffered word.
// - Overrun error clears when continuous receive clears.
// - Status bit holds received ninth bit.
// - Free-running 8-bit baud timer set by divisor.
// - Rate divides by 64, 16, 4 times (X+1).
// - Divisor spans full range zero to 255.
// - Divisor write restarts the baud timer at once.
// - Async receive input majority-voted over three samples.
// - Unused transmit control bit reads zero.
// - Async frame: start, 8/9 data LSB first, stop.
// - Async timer ticks sixteen or sixty-four per bit.
module usc_ctrl
	import usc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	input  wire logic              dtIn,
	input  wire logic              ckIn,
	output var  usc_pin_t          pin
);

	usc_state_t q;
	usc_state_t n;

	// Ticks of the baud timer per bit or per sampling window.
	function automatic logic [6:0] ratioOf(input logic sync, input logic high_speed_select);
		if (sync)
			return {5'h00, `USC_RATIO_SY} + 7'h01;
		return high_speed_select ? `USC_RATIO_HI : `USC_RATIO_LO;
	endfunction

	function automatic logic isMapped(input logic [ADDR_W-1:0] a);
		case (a[7:0])
			`USC_OFF_TXCS, `USC_OFF_RXCS, `USC_OFF_DIV,
			`USC_OFF_TXDATA, `USC_OFF_RXBUF, `USC_OFF_STAT: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// Bit periods in an asynchronous frame: start, data, optional ninth bit and stop.
	function automatic logic [3:0] asyncFrameLen(input logic nine);
		if (nine)
			return 4'hB;
		return 4'hA;
	endfunction

	// Bits in a synchronous word, which carries no start or stop bit.
	function automatic logic [3:0] syncWordLen(input logic nine);
		if (nine)
			return 4'h9;
		return 4'h8;
	endfunction

	// Read image of the transmit control register.
	// The spare bit always reads zero and the empty flag comes from the shifter itself.
	function automatic logic [31:0] txcsImage(input logic [7:0] cs, input logic busy);
		logic [31:0] img;
		img = 32'h00000000;
		img[7:4] = cs[7:4];
		img[`USC_B_HIGH_SPEED_SELECT] = cs[`USC_B_HIGH_SPEED_SELECT];
		img[`USC_B_SHIFT_REGISTER_EMPTY] = ~busy;
		img[`USC_B_TRANSMIT_NINTH_BIT] = cs[`USC_B_TRANSMIT_NINTH_BIT];
		return img;
	endfunction

	// Write image of the transmit control register.
	// Read-only and spare bits are stored as zero so that nothing stale can leak into a read.
	function automatic logic [7:0] txcsWrite(input logic [7:0] w);
		logic [7:0] v;
		v = w;
		v[3] = 1'b0;
		v[`USC_B_SHIFT_REGISTER_EMPTY] = 1'b0;
		return v;
	endfunction

	// Read multiplexer over the whole register map.
	// Upper bits of every register read zero, as do unmapped and write-only offsets.
	function automatic logic [31:0] readImage(input logic [7:0] a, input usc_state_t s);
		logic [31:0] img;
		img = 32'h00000000;
		case (a)
			`USC_OFF_TXCS:  img = txcsImage(s.txcs, s.txBusy);
			`USC_OFF_RXCS:  img[7:0] = s.rxcs;
			`USC_OFF_DIV:   img[7:0] = s.div;
			`USC_OFF_RXBUF: img[7:0] = s.rxBuf;
			`USC_OFF_STAT:  img[1:0] = {s.rxValid, ~s.txFull};
			default:        img = 32'h00000000;
		endcase
		return img;
	endfunction

	logic       tick;
	logic       serial_port_enable;
	logic       sync;
	logic       master;
	logic       rx9;
	logic [6:0] ratio;
	logic [6:0] mid;
	logic       acc;
	logic       txAllowed;
	logic       rxAsyncOn;
	logic       rxSyncOn;
	logic       run;
	logic       sampleEdge;
	logic       shiftEdge;
	logic       bitV;
	logic       deliver;
	logic       dFerr;
	logic [7:0] dData;
	logic       dNine;

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~isMapped(paddr);
	assign prdata  = q.prdata;
	assign pin     = q.pin;

	always_comb begin
		n = q;
		deliver = 1'b0;
		dFerr = 1'b0;
		bitV = 1'b0;
		serial_port_enable = q.rxcs[`USC_B_SERIAL_PORT_ENABLE];
		sync = q.txcs[`USC_B_SYNC];
		master = sync & q.txcs[`USC_B_CLOCK_SOURCE_SELECT];
		rx9 = q.rxcs[`USC_B_RX9];
		ratio = ratioOf(sync, q.txcs[`USC_B_HIGH_SPEED_SELECT]);
		mid = ratio >> 1;
		acc = psel & penable;

		// ==========================================================
		// Baud timer
		// The timer counts down from the divisor and reloads at zero, so one tick spans divisor plus one clocks.
		// A divisor write below overrides the reload and restarts the period at once.
		tick = (q.cnt == 8'h00);
		n.cnt = tick ? q.div : q.cnt - 8'h01;

		// ==========================================================
		// Pin synchronisers
		// Both pins come from outside the clock domain; no logic reads the first flop of either pin.
		// The third clock flop exists only to find edges of the already settled level.
		n.dtS1 = dtIn;
		n.dtS2 = q.dtS1;
		n.ckS1 = ckIn;
		n.ckS2 = q.ckS1;
		n.ckPrev = q.ckS2;

		// ==========================================================
		// Register access
		// Read data are latched in the setup cycle and stand unchanged through the access phase.
		// A pop of the receive buffer happens only at the access edge, after the data were taken.
		if (psel & ~penable)
			n.prdata = readImage(paddr[7:0], q);
		if (acc & pwrite) begin
			case (paddr[7:0])
				`USC_OFF_TXCS: n.txcs = txcsWrite(pwdata[7:0]);
				`USC_OFF_RXCS: begin
					n.rxcs[7:3] = pwdata[7:3];
					if (!pwdata[`USC_B_CONTINUOUS_RECEIVE_ENABLE])
						n.rxcs[`USC_B_OVERRUN_ERROR] = 1'b0;
				end
				`USC_OFF_DIV: begin
					n.div = pwdata[7:0];
					n.cnt = pwdata[7:0];
				end
				`USC_OFF_TXDATA: begin
					if (!q.txFull) begin
						n.txData = pwdata[7:0];
						n.txFull = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (acc & ~pwrite & (paddr[7:0] == `USC_OFF_RXBUF))
			n.rxValid = 1'b0;

		// ==========================================================
		// Synchronous clock and edges
		// The master clock runs only while there is work, so the line rests low between words.
		// In slave mode the edges come from the synchronised clock pin instead.
		rxSyncOn = serial_port_enable & sync & ~q.rxcs[`USC_B_OVERRUN_ERROR] &
			(q.rxcs[`USC_B_CONTINUOUS_RECEIVE_ENABLE] | (master & q.rxcs[`USC_B_SINGLE_RECEIVE_ENABLE]));
		run = master & serial_port_enable & (q.txBusy | rxSyncOn);
		if (!run) begin
			n.ph4 = 2'h0;
			n.ckLvl = 1'b0;
		end else if (tick) begin
			n.ph4 = q.ph4 + 2'h1;
			n.ckLvl = n.ph4[1];
		end
		if (master) begin
			sampleEdge = run & tick & (q.ph4 == 2'h1);
			shiftEdge = run & tick & (q.ph4 == `USC_RATIO_SY);
		end else begin
			sampleEdge = q.ckS2 & ~q.ckPrev;
			shiftEdge = ~q.ckS2 & q.ckPrev;
		end

		// ==========================================================
		// Transmitter
		// Dropping any enable aborts a word in flight; the buffered word then waits for the next enable.
		// In synchronous mode a data bit changes only after the partner has sampled the previous one.
		txAllowed = serial_port_enable & q.txcs[`USC_B_TRANSMIT_ENABLE] &
			~(sync & (q.rxcs[`USC_B_SINGLE_RECEIVE_ENABLE] | q.rxcs[`USC_B_CONTINUOUS_RECEIVE_ENABLE]));
		if (!txAllowed) begin
			n.txBusy = 1'b0;
		end else if (!q.txBusy) begin
			if (q.txFull) begin
				n.txFull = 1'b0;
				n.txBusy = 1'b1;
				n.txPh = 6'h00;
				n.txSmp = 1'b0;
				if (sync) begin
					n.txSh = {2'b00, q.txcs[`USC_B_TRANSMIT_NINTH_BIT], q.txData};
					n.txBits = syncWordLen(q.txcs[`USC_B_TX9]);
				end else if (q.txcs[`USC_B_TX9]) begin
					n.txSh = {1'b1, q.txcs[`USC_B_TRANSMIT_NINTH_BIT], q.txData, 1'b0};
					n.txBits = 4'hB;
				end else begin
					n.txSh = {2'b11, q.txData, 1'b0};
					n.txBits = 4'hA;
				end
			end
		end else if (sync) begin
			if (sampleEdge)
				n.txSmp = 1'b1;
			if (shiftEdge & q.txSmp) begin
				n.txSmp = 1'b0;
				n.txSh = {1'b1, q.txSh[10:1]};
				n.txBits = q.txBits - 4'h1;
				n.txBusy = (q.txBits != 4'h1);
			end
		end else if (tick) begin
			n.txPh = q.txPh + 6'h01;
			if ({1'b0, q.txPh} == ratio - 7'h01) begin
				n.txPh = 6'h00;
				n.txSh = {1'b1, q.txSh[10:1]};
				n.txBits = q.txBits - 4'h1;
				n.txBusy = (q.txBits != 4'h1);
			end
		end

		// ==========================================================
		// Receiver
		// A start bit that votes high is taken as a glitch and the receiver returns to hunting.
		// The stop bit is judged at its middle, so the receiver is idle again well before the next start.
		// Reception stops while an overrun is flagged, until software clears the continuous enable.
		rxAsyncOn = serial_port_enable & ~sync & q.rxcs[`USC_B_CONTINUOUS_RECEIVE_ENABLE] & ~q.rxcs[`USC_B_OVERRUN_ERROR];
		if (sync) begin
			if (!rxSyncOn) begin
				n.rxBits = syncWordLen(rx9);
			end else if (sampleEdge) begin
				n.rxSh = {q.dtS2, q.rxSh[8:1]};
				n.rxBits = q.rxBits - 4'h1;
				if (q.rxBits == 4'h1) begin
					deliver = 1'b1;
					n.rxBits = syncWordLen(rx9);
					if (!q.rxcs[`USC_B_CONTINUOUS_RECEIVE_ENABLE])
						n.rxcs[`USC_B_SINGLE_RECEIVE_ENABLE] = 1'b0;
				end
			end
			n.rxBusy = 1'b0;
		end else if (!rxAsyncOn) begin
			n.rxBusy = 1'b0;
		end else if (!q.rxBusy) begin
			if (!q.dtS2) begin
				n.rxBusy = 1'b1;
				n.rxPh = 6'h00;
				n.rxVote = 2'h0;
				n.rxBits = asyncFrameLen(rx9);
			end
		end else if (tick) begin
			n.rxPh = q.rxPh + 6'h01;
			if ({1'b0, q.rxPh} == ratio - 7'h01)
				n.rxPh = 6'h00;
			if (({1'b0, q.rxPh} == mid - 7'h01) || ({1'b0, q.rxPh} == mid))
				n.rxVote = q.rxVote + {1'b0, q.dtS2};
			if ({1'b0, q.rxPh} == mid + 7'h01) begin
				bitV = ({1'b0, q.rxVote} + {2'b00, q.dtS2}) >= 3'h2;
				n.rxVote = 2'h0;
				n.rxBits = q.rxBits - 4'h1;
				if ((q.rxBits == asyncFrameLen(rx9)) && bitV) begin
					n.rxBusy = 1'b0;
				end else if (q.rxBits == 4'h1) begin
					n.rxBusy = 1'b0;
					deliver = ~rx9 | ~q.rxcs[`USC_B_ADDRESS_DETECT_ENABLE] | q.rxSh[8];
					dFerr = ~bitV;
				end else if (q.rxBits != asyncFrameLen(rx9)) begin
					n.rxSh = {bitV, q.rxSh[8:1]};
				end
			end
		end

		// The buffer is checked after any pop in this cycle, so a read and a new word never collide.
		dData = rx9 ? n.rxSh[7:0] : n.rxSh[8:1];
		dNine = rx9 & n.rxSh[8];
		if (deliver) begin
			if (n.rxValid) begin
				n.rxcs[`USC_B_OVERRUN_ERROR] = 1'b1;
			end else begin
				n.rxBuf = dData;
				n.rxValid = 1'b1;
				n.rxcs[`USC_B_FRAMING_ERROR] = dFerr;
				n.rxcs[`USC_B_RECEIVE_NINTH_BIT] = dNine;
			end
		end

		// ==========================================================
		// Pins
		// Pin values are taken from the next state so that they leave a flop in step with the shifter.
		// The asynchronous transmit line idles high, the synchronous clock idles low.
		n.pin.dtOe = serial_port_enable & sync & n.txBusy;
		n.pin.dtOut = n.txBusy ? n.txSh[0] : 1'b1;
		if (!sync) begin
			n.pin.ckOe = serial_port_enable;
			n.pin.ckOut = n.txBusy ? n.txSh[0] : 1'b1;
		end else begin
			n.pin.ckOe = serial_port_enable & master;
			n.pin.ckOut = master & n.ckLvl;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
			q.txcs <= `USC_TXCS_RST;
			q.rxcs <= `USC_RXCS_RST;
			q.div <= `USC_DIV_RST;
			q.rxBits <= 4'hA;
		end else begin
			q <= n;
		end
	end

endmodule // usc_ctrl
`default_nettype wire

// File: sim/usc_ctrl_monitor.sv
// Checker for the register bus and pin enables of the serial transceiver.
`timescale 1ns/10ps
`default_nettype none
module usc_ctrl_monitor
	import usc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic              clk,
	input wire logic              rst_b,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              dtIn,
	input wire logic              ckIn,
	input wire usc_pin_t          pin
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ==========
	// Shadow of divisor and port enable
	wire logic acc = psel && penable;
	logic [7:0] divQ;
	logic       spenQ;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			divQ  <= 8'h00;
			spenQ <= 1'b0;
		end else if (acc && pwrite) begin
			if (paddr == 8'h08) divQ <= pwdata[7:0];
			if (paddr == 8'h04) spenQ <= pwdata[7];
		end
	end
	// ==========
	// Assertions
	pready_high_a: assert property (pready)
		else $error("pready low");
	slverr_hole_a: assert property (acc && paddr > 8'h14 |-> pslverr)
		else $error("no error on unmapped address");
	slverr_map_a: assert property (acc && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("error on mapped address");
	slverr_idle_a: assert property (!acc |-> !pslverr)
		else $error("error outside access");
	spare_bit_a: assert property (acc && !pwrite && paddr == 8'h00 |-> prdata[3] == 1'b0)
		else $error("unused bit set");
	upper_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	div_read_a: assert property (acc && !pwrite && paddr == 8'h08 |-> prdata[7:0] == divQ)
		else $error("divisor readback wrong");
	port_pins_a: assert property ($changed(spenQ) |-> ##[1:3] pin.ckOe == spenQ)
		else $error("pin enable not following port enable");
	cover property (acc && pwrite && paddr == 8'h0C);
	cover property (acc && pslverr);
	cover property ($fell(pin.ckOut));
endmodule // usc_ctrl_monitor
bind usc_ctrl usc_ctrl_monitor #(.ADDR_W(ADDR_W)) i_mon (.clk(clk), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .dtIn(dtIn), .ckIn(ckIn), .pin(pin));
`default_nettype wire

// File: sim/usc_term.sv
// Model of the serial terminal on the far side of the link.
`timescale 1ns/10ps
`default_nettype none
module usc_term (
	input  wire logic clk,
	output var  logic dtIn,
	output var  logic ckIn
);
	initial begin
		dtIn = 1'b1;
		ckIn = 1'b0;
	end
	// Sends one frame; the line idles high like a pulled-up terminal output.
	task automatic send_word(input logic [7:0] d, input int bt);
		logic [9:0] fr;
		fr = {1'b1, d, 1'b0};
		@(posedge clk);
		for (int i = 0; i < 10; i++) begin
			dtIn <= fr[i];
			repeat (bt) @(posedge clk);
		end
	endtask
endmodule // usc_term
`default_nettype wire

// File: sim/usart_control_and_baud_generator_test.sv
// Self-checking bench of the serial transceiver control block.
`timescale 1ns/10ps
`default_nettype none
module usart_control_and_baud_generator_test;
	import usc_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	wire logic   dtIn;
	wire logic   ckIn;
	usc_pin_t    pin;
	logic [31:0] rd;
	logic        err;
	int          bad_count = 0;
	int          n_compared = 0;
	always #4 clk = ~clk;
	usc_ctrl i_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dtIn(dtIn), .ckIn(ckIn), .pin(pin));
	usc_term i_term (.clk(clk), .dtIn(dtIn), .ckIn(ckIn));
	// ==========
	// Bus and compare tasks
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic txchk(input logic [7:0] d, input int bt);
		logic [9:0] fr;
		apb(1'b1, 8'h0C, {24'h000000, d});
		for (int i = 0; i < 300 && pin.ckOut !== 1'b0; i++) @(posedge clk);
		repeat (bt / 2) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			fr[i] = pin.ckOut;
			repeat (bt) @(posedge clk);
		end
		chk("frame", {22'h0, 1'b1, d, 1'b0}, {22'h0, fr});
	endtask
	task automatic end_sim;
		if (bad_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==========
	// Tests
	initial begin
		#200000;
		bad_count++;
		end_sim();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk("txcs", 32'h02, rd);
		apb(1'b0, 8'h04, 32'h0);
		chk("rxcs", 32'h00, rd);
		apb(1'b1, 8'h00, 32'hFF);
		apb(1'b0, 8'h00, 32'h0);
		chk("txcs", 32'hF7, rd);
		apb(1'b1, 8'h08, 32'hFF);
		apb(1'b0, 8'h08, 32'h0);
		chk("div", 32'hFF, rd);
		apb(1'b0, 8'h18, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b1, 8'h00, 32'h24);
		apb(1'b1, 8'h04, 32'h80);
		txchk(8'hA5, 16);
		repeat (20) @(posedge clk);
		apb(1'b0, 8'h00, 32'h0);
		chk("txcs", 32'h26, rd);
		apb(1'b1, 8'h00, 32'h20);
		apb(1'b1, 8'h08, 32'h01);
		txchk(8'h5A, 128);
		apb(1'b1, 8'h00, 32'h24);
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b1, 8'h04, 32'h90);
		i_term.send_word(8'h3C, 16);
		repeat (40) @(posedge clk);
		apb(1'b0, 8'h14, 32'h0);
		chk("status", 32'h03, rd);
		apb(1'b0, 8'h10, 32'h0);
		chk("rxbuf", 32'h3C, rd);
		apb(1'b0, 8'h04, 32'h0);
		chk("rxcs", 32'h90, rd);
		i_term.send_word(8'h11, 16);
		i_term.send_word(8'h22, 16);
		repeat (40) @(posedge clk);
		apb(1'b0, 8'h04, 32'h0);
		chk("rxcs", 32'h92, rd);
		apb(1'b0, 8'h10, 32'h0);
		chk("rxbuf", 32'h11, rd);
		apb(1'b1, 8'h04, 32'h80);
		apb(1'b0, 8'h04, 32'h0);
		chk("rxcs", 32'h80, rd);
		end_sim();
	end
endmodule // usart_control_and_baud_generator_test
`default_nettype wire
